/* can_cfg_defines.svh */
// Offsets, field positions, reset values and codes of the CAN configuration block
`ifndef CAN_CFG_DEFINES_SVH
`define CAN_CFG_DEFINES_SVH

// ***************************************************
// Register byte offsets
// ***************************************************
`define OFS_PROTOCOL_SELECT 8'h00
`define OFS_NODE_ADDRESS 8'h04
`define OFS_BIT_RATE_SELECT 8'h08
`define OFS_BUS_OFF_POLICY 8'h0c
`define OFS_CONTROLLER_STATE 8'h10
`define OFS_RX_TELEGRAM_COUNT 8'h14
`define OFS_TX_TELEGRAM_COUNT 8'h18
`define OFS_BUS_OFF_COUNT 8'h1c
`define OFS_LOST_MESSAGE_COUNT 8'h20
`define OFS_COMM_STATUS 8'h24
`define OFS_NODE_STATE 8'h28
`define OFS_ACTIVE_CONFIG 8'h2c

// ***************************************************
// Reset values and codes
// ***************************************************
`define RST_PROTOCOL_SELECT 16'h0002
`define RST_NODE_ADDRESS 16'h003f
`define RST_BIT_RATE_SELECT 16'h0000
`define RST_BUS_OFF_POLICY 16'h0000
`define PROTO_CANOPEN 16'h0001
`define PROTO_DEVICENET 16'h0002
`define ADDR_CANOPEN_MIN 16'h0001
`define ADDR_CANOPEN_MAX 16'h007f
`define ADDR_DEVICENET_MAX 16'h003f
`define RATE_CODE_MAX 16'h0008
`define RATE_500K 16'h0002
`define RATE_250K 16'h0003
`define RATE_125K 16'h0004
`define POLICY_AUTO 16'h0001

// ***************************************************
// Field positions in the active configuration word
// ***************************************************
`define ACT_ADDR_LSB 0
`define ACT_RATE_LSB 8
`define ACT_PROTO_LSB 12
`define ACT_COMM_OFF_BIT 14

`endif

/* can_cfg_pkg.sv */
// Types shared by the CAN configuration and status block
package can_cfg_pkg;

   typedef enum logic [2:0] {
      CTRL_ABSENT = 3'h0,
      CTRL_AUTOBAUD = 3'h1,
      CTRL_ACTIVE = 3'h2,
      CTRL_WARNING = 3'h3,
      CTRL_ERR_PASSIVE = 3'h4,
      CTRL_BUS_OFF = 3'h5,
      CTRL_NO_POWER = 3'h6
   } ctrl_code_t;

   typedef enum logic [3:0] {
      ST_OFF = 4'b0001,
      ST_BAUD = 4'b0010,
      ST_RUN = 4'b0100,
      ST_HALT = 4'b1000
   } link_state_t;

   // Events and levels reported by the CAN controller
   typedef struct packed {
      logic present;
      logic powered;
      logic rx_done;
      logic tx_done;
      logic rx_lost;
      logic warning;
      logic err_passive;
      logic bus_off;
      logic baud_found;
      logic [3:0] baud_code;
      logic [2:0] comm_status;
      logic [2:0] node_state;
   } ctrl_in_t;

   // Settings applied to the CAN controller
   typedef struct packed {
      logic [6:0] node_addr;
      logic [3:0] rate_code;
      logic autobaud;
      logic enable;
      logic restart;
   } ctrl_out_t;

endpackage

/* can_cfg_status.sv */
// CAN interface configuration, supervision and statistics with an AXI4-Lite slave
//
// Behaviour
// - Address range depends on protocol, default 63
// - New address applied only unpowered/autobaud/power-up
// - Bit-rate codes 0..8, default 1 Mbit/s
// - CANopen: all rates fixed, never autobaud
// - DeviceNet: 500/250/125 fixed, else autobaud
// - New rate applied only unpowered/power-up
// - Detected rate overwrites setting; rerun needs rewrite
// - Manual policy: alarm, fault action, comm off
// - Automatic policy: restart, no alarm/fault action
// - Controller status codes 0..6
// - Autobaud status only under DeviceNet
// - Received telegram counter, 16 bit
// - Transmitted telegram counter, 16 bit
// - Counters clear at reset, wrap at max
// - Bus-off counter counts bus-off entries
// - Lost message counter, 16 bit
// - CANopen communication status codes 0..5
// - CANopen node state codes 0..4
// - Protocol 1=CANopen 2=DeviceNet, power-up only
`timescale 1ns/1ps
`include "can_cfg_defines.svh"

module can_cfg_status
   import can_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ctrl_in_t ctrl_in,
   output ctrl_out_t ctrl_out,
   output logic bus_off_alarm,
   output logic comm_fault_action
);

   // ***************************************************
   // Functions
   // ***************************************************
   function automatic logic addr_ok(input logic [15:0] proto, input logic [15:0] a);
      if (proto == `PROTO_CANOPEN)
         addr_ok = (a >= `ADDR_CANOPEN_MIN) && (a <= `ADDR_CANOPEN_MAX);
      else
         addr_ok = (a <= `ADDR_DEVICENET_MAX);
   endfunction

   function automatic logic rate_is_fixed(input logic [15:0] proto, input logic [15:0] r);
      if (proto == `PROTO_CANOPEN)
         rate_is_fixed = 1'b1;
      else
         rate_is_fixed = (r == `RATE_500K) || (r == `RATE_250K) || (r == `RATE_125K);
   endfunction

   // ***************************************************
   // Registers
   // ***************************************************
   logic [15:0] protocol_select_q;
   logic [15:0] node_address_q;
   logic [15:0] bit_rate_select_q;
   logic [15:0] bus_off_policy_q;
   logic [15:0] act_proto_q;
   logic [6:0] act_addr_q;
   logic [3:0] act_rate_q;
   logic baud_pending_q;
   logic [15:0] cnt_q [4];
   logic bus_off_seen_q;
   link_state_t state_q;
   ctrl_code_t ctrl_code;
   logic aw_held_q;
   logic w_held_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire;
   logic bus_off_rise;
   logic halt_now;
   logic [15:0] wval;
   logic [3:0] evt;

   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wval = wdata_q[15:0];
   assign bus_off_rise = ctrl_in.bus_off && !bus_off_seen_q;
   // Same condition as the move to the halted state, so alarm and enable switch together
   assign halt_now = bus_off_rise && bus_off_policy_q != `POLICY_AUTO && state_q == ST_RUN &&
      ctrl_in.powered;

   // ***************************************************
   // AXI4-Lite write channel
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_q <= `OFS_ACTIVE_CONFIG && awaddr_q[1:0] == 2'h0)
               ? 2'h0 : 2'h3;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // ***************************************************
   // Software settings
   // ***************************************************
   // Out-of-range writes are refused; a detected autobaud rate is stored without a range check
   always_ff @(posedge clk) begin
      if (rst) begin
         protocol_select_q <= `RST_PROTOCOL_SELECT;
         node_address_q <= `RST_NODE_ADDRESS;
         bit_rate_select_q <= `RST_BIT_RATE_SELECT;
         bus_off_policy_q <= `RST_BUS_OFF_POLICY;
         baud_pending_q <= 1'b0;
      end else begin
         if (wr_fire && wstrb_q[1:0] == 2'h3) begin
            if (awaddr_q == `OFS_PROTOCOL_SELECT &&
                (wval == `PROTO_CANOPEN || wval == `PROTO_DEVICENET))
               protocol_select_q <= wval;
            if (awaddr_q == `OFS_NODE_ADDRESS && addr_ok(protocol_select_q, wval))
               node_address_q <= wval;
            if (awaddr_q == `OFS_BIT_RATE_SELECT && wval <= `RATE_CODE_MAX)
               bit_rate_select_q <= wval;
            if (awaddr_q == `OFS_BUS_OFF_POLICY && wval <= `POLICY_AUTO)
               bus_off_policy_q <= wval;
         end
         if (state_q == ST_BAUD && ctrl_in.baud_found) begin
            bit_rate_select_q <= {12'h000, ctrl_in.baud_code};
            baud_pending_q <= 1'b0;
         end
         // rewrite of autobaud code rearms detection
         if (wr_fire && wstrb_q[1:0] == 2'h3 && awaddr_q == `OFS_BIT_RATE_SELECT &&
             wval <= `RATE_CODE_MAX && !rate_is_fixed(act_proto_q, wval))
            baud_pending_q <= 1'b1;
      end
   end

   // ***************************************************
   // Link supervision
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_OFF;
      end else begin
         unique case (state_q)
            ST_OFF: begin
               if (ctrl_in.present && ctrl_in.powered)
                  // CANopen never autobauds; DeviceNet fixed set
                  state_q <= rate_is_fixed(act_proto_q, {12'h000, act_rate_q})
                     ? ST_RUN : ST_BAUD;
            end
            ST_BAUD: begin
               if (!ctrl_in.powered)
                  state_q <= ST_OFF;
               else if (ctrl_in.baud_found)
                  state_q <= ST_RUN;
            end
            ST_RUN: begin
               if (!ctrl_in.powered)
                  state_q <= ST_OFF;
               else if (bus_off_rise && bus_off_policy_q != `POLICY_AUTO)
                  state_q <= ST_HALT;
               else if (baud_pending_q)
                  state_q <= ST_BAUD;
            end
            // Only a power cycle (reset) leaves the halted state
            ST_HALT: state_q <= ST_HALT;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         act_proto_q <= `RST_PROTOCOL_SELECT;
         act_addr_q <= 7'h3f;
         act_rate_q <= 4'h0;
      end else begin
         // address taken while unpowered or in autobaud
         if (state_q == ST_OFF || state_q == ST_BAUD)
            act_addr_q <= node_address_q[6:0];
         if (state_q == ST_OFF)
            act_rate_q <= bit_rate_select_q[3:0];
         else if (state_q == ST_BAUD && ctrl_in.baud_found)
            act_rate_q <= ctrl_in.baud_code;
         if (state_q == ST_OFF && act_proto_q == `RST_PROTOCOL_SELECT &&
             !ctrl_in.present)
            act_proto_q <= protocol_select_q;
      end
   end

   // ***************************************************
   // Outputs to the controller and alarms
   // ***************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_out <= '0;
         bus_off_alarm <= 1'b0;
         comm_fault_action <= 1'b0;
         bus_off_seen_q <= 1'b0;
      end else begin
         bus_off_seen_q <= ctrl_in.bus_off;
         ctrl_out.node_addr <= act_addr_q;
         ctrl_out.rate_code <= act_rate_q;
         ctrl_out.autobaud <= (state_q == ST_BAUD);
         ctrl_out.enable <= ((state_q == ST_RUN) && !halt_now) || (state_q == ST_BAUD);
         ctrl_out.restart <= bus_off_rise && bus_off_policy_q == `POLICY_AUTO &&
            state_q == ST_RUN;
         // alarm and fault action stay until power cycle
         if (halt_now) begin
            bus_off_alarm <= 1'b1;
            comm_fault_action <= 1'b1;
         end
      end
   end

   // ***************************************************
   // Controller status code
   // ***************************************************
   // status code priority; autobaud only under DeviceNet
   always_comb begin
      if (!ctrl_in.present)
         ctrl_code = CTRL_ABSENT;
      else if (!ctrl_in.powered)
         ctrl_code = CTRL_NO_POWER;
      else if (ctrl_in.bus_off || state_q == ST_HALT)
         ctrl_code = CTRL_BUS_OFF;
      else if (state_q == ST_BAUD && act_proto_q == `PROTO_DEVICENET)
         ctrl_code = CTRL_AUTOBAUD;
      else if (ctrl_in.err_passive)
         ctrl_code = CTRL_ERR_PASSIVE;
      else if (ctrl_in.warning)
         ctrl_code = CTRL_WARNING;
      else
         ctrl_code = CTRL_ACTIVE;
   end

   // ***************************************************
   // Statistics counters
   // ***************************************************
   assign evt = {ctrl_in.rx_lost, bus_off_rise, ctrl_in.tx_done, ctrl_in.rx_done};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_cnt
         // clear on reset, natural 16-bit wrap
         always_ff @(posedge clk) begin
            if (rst)
               cnt_q[gi] <= 16'h0000;
            else if (evt[gi])
               cnt_q[gi] <= cnt_q[gi] + 16'h0001;
         end
      end
   endgenerate

   // ***************************************************
   // AXI4-Lite read channel
   // ***************************************************
   // status and counters have no write path
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
            unique case (s_axi_araddr)
               `OFS_PROTOCOL_SELECT: s_axi_rdata[15:0] <= protocol_select_q;
               `OFS_NODE_ADDRESS: s_axi_rdata[15:0] <= node_address_q;
               `OFS_BIT_RATE_SELECT: s_axi_rdata[15:0] <= bit_rate_select_q;
               `OFS_BUS_OFF_POLICY: s_axi_rdata[15:0] <= bus_off_policy_q;
               `OFS_CONTROLLER_STATE: s_axi_rdata[2:0] <= ctrl_code;
               `OFS_RX_TELEGRAM_COUNT: s_axi_rdata[15:0] <= cnt_q[0];
               `OFS_TX_TELEGRAM_COUNT: s_axi_rdata[15:0] <= cnt_q[1];
               `OFS_BUS_OFF_COUNT: s_axi_rdata[15:0] <= cnt_q[2];
               `OFS_LOST_MESSAGE_COUNT: s_axi_rdata[15:0] <= cnt_q[3];
               `OFS_COMM_STATUS: s_axi_rdata[2:0] <= ctrl_in.comm_status;
               `OFS_NODE_STATE: s_axi_rdata[2:0] <= ctrl_in.node_state;
               `OFS_ACTIVE_CONFIG: begin
                  s_axi_rdata[`ACT_ADDR_LSB +: 7] <= act_addr_q;
                  s_axi_rdata[`ACT_RATE_LSB +: 4] <= act_rate_q;
                  s_axi_rdata[`ACT_PROTO_LSB +: 2] <= act_proto_q[1:0];
                  s_axi_rdata[`ACT_COMM_OFF_BIT] <= (state_q == ST_HALT);
               end
               default: s_axi_rresp <= 2'h3;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

/* can_cfg_status_props.sv */
// Port checker for the CAN configuration block
`timescale 1ns/1ps
module can_cfg_status_props
   import can_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ctrl_in_t ctrl_in,
   input wire ctrl_out_t ctrl_out,
   input wire logic bus_off_alarm,
   input wire logic comm_fault_action
);
   // ***************************
   // Checks
   // ***************************
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_b_stand: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
   a_r_stand: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_alarm_sticky: assert property (bus_off_alarm |=> bus_off_alarm)
      else $error("alarm cleared without reset");
   a_fault_pair: assert property ($rose(bus_off_alarm) |-> $rose(comm_fault_action))
      else $error("fault action not with alarm");
   a_halt_off: assert property (bus_off_alarm |-> !ctrl_out.enable)
      else $error("comm enabled after bus off");
   a_restart_quiet: assert property (ctrl_out.restart |-> !bus_off_alarm)
      else $error("alarm with automatic restart");
   a_restart_pulse: assert property (ctrl_out.restart |=> !ctrl_out.restart)
      else $error("restart too long");
   a_cfg_held: assert property ((ctrl_in.powered && !ctrl_out.autobaud)[*4]
      |-> $stable(ctrl_out.rate_code) && $stable(ctrl_out.node_addr))
      else $error("setting applied while running");
endmodule

bind can_cfg_status can_cfg_status_props i_props (.clk(clk), .rst(rst),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .ctrl_in(ctrl_in), .ctrl_out(ctrl_out),
   .bus_off_alarm(bus_off_alarm), .comm_fault_action(comm_fault_action));

/* can_ctrl_model.sv */
// Behavioural CAN controller and network facing the configuration block
`timescale 1ns/1ps
module can_ctrl_model
   import can_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire ctrl_out_t ctrl_out,
   input wire logic [4:0] lvl,
   input wire logic [2:0] ev,
   input wire logic [5:0] co,
   input wire logic [3:0] net_rate,
   output ctrl_in_t ctrl_in
);
   // ***************************
   // Controller
   // ***************************
   logic [3:0] hunt_q;
   logic [2:0] ev_d;
   always_ff @(posedge clk) begin
      if (rst || !ctrl_out.autobaud) begin
         hunt_q <= 4'h0;
      end else if (hunt_q != 4'hf) begin
         hunt_q <= hunt_q + 4'h1;
      end
   end
   assign ev_d = ev & {3{ctrl_out.enable}};
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_in <= '0;
      end else begin
         ctrl_in <= {lvl[4:3], ev_d, lvl[2:0], hunt_q == 4'hc,
            (hunt_q == 4'hc) ? net_rate : ~net_rate, co};
      end
   end
endmodule

/* tb_top.sv */
// Self-checking bench for the CAN configuration block
`timescale 1ns/1ps
module tb_top;
   import can_cfg_pkg::*;
   logic clk;
   logic rst = 1'b1;
   logic [7:0] awa = 8'h00;
   logic [7:0] ara = 8'h00;
   logic [31:0] wdt = 32'h0;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic brd = 1'b0;
   logic arv = 1'b0;
   logic rrd = 1'b0;
   logic [4:0] lvl = 5'h00;
   logic [2:0] ev = 3'h0;
   logic [5:0] cst = 6'h00;
   logic [3:0] nrate = 4'h0;
   logic seen_rs = 1'b0;
   logic awr, wrd, bv, arr, rv, alarm, fault;
   logic [1:0] brs, rrs, resp;
   logic [31:0] rdt;
   ctrl_in_t ci;
   ctrl_out_t cob;
   int n_mismatch = 0;
   int checked = 0;
   can_cfg_status i_can_cfg_status (.clk(clk), .rst(rst), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdt), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(brs), .s_axi_bvalid(bv),
      .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rrd),
      .ctrl_in(ci), .ctrl_out(cob), .bus_off_alarm(alarm), .comm_fault_action(fault));
   can_ctrl_model i_can_ctrl_model (.clk(clk), .rst(rst), .ctrl_out(cob), .lvl(lvl),
      .ev(ev), .co(cst), .net_rate(nrate), .ctrl_in(ci));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (cob.restart === 1'b1) seen_rs <= 1'b1;
   end
   // ***************************
   // Helpers
   // ***************************
   task automatic close_out;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         $display("mismatch at %0t got %h exp %h", $time, g, e);
         n_mismatch++;
      end
   endtask
   task automatic tmo;
      n_mismatch++;
      close_out();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic ta, tw, tb, sb, dn;
      @(posedge clk);
      awa <= a;
      wdt <= {16'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      dn = 1'b0;
      for (int n = 0; n < 64 && !dn; n++) begin
         @(negedge clk);
         ta = awv && awr;
         tw = wv && wrd;
         tb = bv && brd;
         sb = bv;
         resp = brs;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (sb && !tb) brd <= 1'b1;
         if (tb) brd <= 1'b0;
         dn = tb;
      end
      if (!dn) tmo();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic ta, tr, sr, dn;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      dn = 1'b0;
      for (int n = 0; n < 64 && !dn; n++) begin
         @(negedge clk);
         ta = arv && arr;
         tr = rv && rrd;
         sr = rv;
         d = rdt;
         resp = rrs;
         @(posedge clk);
         if (ta) arv <= 1'b0;
         if (sr && !tr) rrd <= 1'b1;
         if (tr) rrd <= 1'b0;
         dn = tr;
      end
      if (!dn) tmo();
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(d, e);
   endtask
   // Waits a bounded time for address, rate and autobaud at the controller
   task automatic wo(input logic [11:0] e);
      for (int n = 0; n < 32 && cob[13:2] !== e; n++) @(negedge clk);
      chk(cob[13:2], e);
   endtask
   task automatic do_rst;
      lvl <= 5'h00;
      rst <= 1'b1;
      cyc(8);
      rst <= 1'b0;
   endtask
   // ***************************
   // Scenarios
   // ***************************
   task automatic t_defaults;
      logic [31:0] ex [9] = '{32'h2, 32'h3f, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 9; i++) begin
         rdc(8'(i * 4), ex[i]);
      end
   endtask
   task automatic t_canopen;
      wr(8'h00, 16'h0001);
      wr(8'h04, 16'h0000);
      rdc(8'h04, 32'h3f);
      wr(8'h04, 16'h007f);
      lvl <= 5'b10000;
      for (int c = 0; c < 9; c++) begin
         wr(8'h08, 16'(c));
         wo({7'h7f, 4'(c), 1'b0});
      end
      rdc(8'h00, 32'h1);
      lvl <= 5'b11000;
      cyc(20);
      chk(cob.autobaud, 1'b0);
      rdc(8'h10, 32'h2);
   endtask
   task automatic t_devicenet;
      lvl <= 5'b10000;
      wr(8'h04, 16'h0040);
      rdc(8'h04, 32'h3f);
      wr(8'h04, 16'h0005);
      wr(8'h08, 16'h0003);
      wo({7'h05, 4'h3, 1'b0});
      lvl <= 5'b11000;
      cyc(10);
      wr(8'h04, 16'h0009);
      wr(8'h08, 16'h0004);
      cyc(10);
      wo({7'h05, 4'h3, 1'b0});
      nrate <= 4'h2;
      wr(8'h08, 16'h0007);
      rdc(8'h10, 32'h1);
      wo({7'h09, 4'h2, 1'b0});
      rdc(8'h08, 32'h2);
      cyc(40);
      chk(cob.autobaud, 1'b0);
   endtask
   task automatic t_status;
      logic [4:0] lv [4] = '{5'b11000, 5'b11100, 5'b11110, 5'b10000};
      logic [31:0] ex [4] = '{32'h2, 32'h3, 32'h4, 32'h6};
      for (int i = 0; i < 4; i++) begin
         lvl <= lv[i];
         cyc(3);
         rdc(8'h10, ex[i]);
      end
      lvl <= 5'b11000;
      for (int i = 0; i < 5; i++) begin
         cst <= {3'(i), 3'(i)};
         cyc(3);
         rdc(8'h24, 32'(i));
         rdc(8'h28, 32'(i));
      end
   endtask
   task automatic t_counters;
      logic [31:0] d;
      ev <= 3'b111;
      cyc(3);
      ev <= 3'b000;
      cyc(4);
      rdc(8'h14, 32'h3);
      rdc(8'h18, 32'h3);
      rdc(8'h20, 32'h3);
      wr(8'h14, 16'h0000);
      chk(resp, 32'h0);
      rdc(8'h14, 32'h3);
      rd(8'h40, d);
      chk(resp, 2'h3);
      ev <= 3'b100;
      cyc(65536);
      ev <= 3'b000;
      cyc(4);
      rdc(8'h14, 32'h3);
   endtask
   task automatic t_bus_off;
      wr(8'h0c, 16'h0001);
      lvl <= 5'b11001;
      cyc(10);
      chk({seen_rs, alarm, fault}, 3'b100);
      rdc(8'h1c, 32'h1);
      lvl <= 5'b11000;
      wr(8'h0c, 16'h0000);
      lvl <= 5'b11001;
      cyc(10);
      chk({alarm, fault, cob.enable}, 3'b110);
      rdc(8'h10, 32'h5);
      rdc(8'h1c, 32'h2);
   endtask
   initial begin
      cyc(8);
      rst <= 1'b0;
      t_defaults();
      t_canopen();
      do_rst();
      t_devicenet();
      t_status();
      t_counters();
      t_bus_off();
      do_rst();
      t_defaults();
      chk(alarm, 1'b0);
      close_out();
   end
endmodule
